// ### src/csdv_pkg.sv
// package for the configuration store discard / verify block
// assumes a single 50 MHz clock and an avalon-mm slave register port
package csdv_pkg;
    localparam logic [31:0] CSDV_KEY_SAVE    = 32'h65766173;
    localparam logic [31:0] CSDV_KEY_DISCARD = 32'h64616F6C;
    localparam logic [31:0] CSDV_KEY_REBOOT  = 32'h746F6F62;
    localparam logic [31:0] CSDV_SAVE_DONE   = 32'h00000001;
    // word addresses: 0x00..0x0F save subindex n, 0x10..0x1F discard subindex n, 0x20 reboot
    localparam logic [7:0]  CSDV_OFS_SAVE    = 8'h00;
    localparam logic [7:0]  CSDV_OFS_DISC    = 8'h10;
    localparam logic [7:0]  CSDV_OFS_REBOOT  = 8'h20;
    localparam logic [7:0]  CSDV_OFS_MARK1   = 8'h21;
    localparam logic [7:0]  CSDV_OFS_MARK2   = 8'h22;
    localparam logic [7:0]  CSDV_OFS_OBJ     = 8'h23;
    localparam logic [7:0]  CSDV_OFS_STATUS  = 8'h24;
    localparam logic [7:0]  CSDV_OFS_BUSY    = 8'h25;
    // category mask bits (from subindex codes)
    localparam logic [3:0]  CSDV_SUB_ALL     = 4'h1;
    localparam logic [3:0]  CSDV_SUB_TUNING  = 4'h6;
    localparam logic [3:0]  CSDV_SUB_RTU     = 4'hB;
    localparam logic [3:0]  CSDV_SUB_ETH     = 4'hC;
    localparam logic [15:0] CSDV_CAT_VALID   = 16'h187C;
    localparam logic [15:0] CSDV_CAT_FACTORY = 16'h003C;
    // save duration, 1 ms at 50 MHz; shortened by parameter in simulation
    localparam int          CSDV_SAVE_US     = 1000;
    localparam int          CSDV_CLK_MHZ     = 50;
    localparam int          CSDV_SAVE_CYC    = CSDV_SAVE_US * CSDV_CLK_MHZ;
    localparam logic [31:0] CSDV_ZERO        = 32'h00000000;
    typedef enum logic [2:0] {
        CSDV_IDLE = 3'b001,
        CSDV_SAVE = 3'b010,
        CSDV_DONE = 3'b100
    } csdv_state_t;
endpackage

// ### src/csdv_store.sv
// configuration store control: save, discard, reboot and modification markers
// assumes avalon-mm master holding requests until waitrequest low
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module csdv_store
    import csdv_pkg::*;
#(
    parameter int SAVE_CYC = CSDV_SAVE_CYC      // save duration in cycles
)(
    input  wire logic        sys_clk_in,         // 50 MHz clock
    input  wire logic        rst_in,             // sync reset, high
    input  wire logic [7:0]  avs_address_in,     // word address
    input  wire logic        avs_read_in,        // read strobe
    input  wire logic        avs_write_in,       // write strobe
    input  wire logic [31:0] avs_writedata_in,   // write data
    output logic      [31:0] avs_readdata_out,   // read data
    output logic             avs_waitrequest_out,// stall
    output logic             restart_out,        // one-cycle controller restart
    output logic      [15:0] save_cat_out,       // categories being saved
    output logic      [15:0] discard_pend_out    // categories discarded at restart
);
    csdv_state_t state_reg, state_next;
    logic [31:0] save_sub_reg [16];
    logic [31:0] save_sub_next [16];
    logic [31:0] mark1_reg, mark1_next, mark2_reg, mark2_next;
    logic [15:0] disc_reg, disc_next, scat_reg, scat_next;
    logic [3:0]  ssub_reg, ssub_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ack_reg, ack_next, rst_o_reg, rst_o_next;
    logic        wait_next;
    logic [31:0] smark1_reg, smark1_next, smark2_reg, smark2_next;

    // map a subindex to its category mask
    function automatic logic [15:0] cat_mask(input logic [3:0] sub);
        logic [15:0] m;
        m = 16'h0000;
        if (sub == CSDV_SUB_ALL)
            m = CSDV_CAT_FACTORY;
        else
            m = CSDV_CAT_VALID & (16'h0001 << sub);
        return m;
    endfunction

    // true when a word address falls in the 16-word group of a base offset
    function automatic logic grp_hit(input logic [7:0] a, input logic [7:0] base);
        return a[7:4] == base[7:4];
    endfunction

    logic acc, wr, rd;
    logic [3:0] sub;
    assign acc = (avs_read_in | avs_write_in) & ~ack_reg;
    assign wr  = avs_write_in & ~ack_reg;
    assign rd  = avs_read_in & ~ack_reg;
    assign sub = avs_address_in[3:0];

    // next-state logic for bus, save engine, markers
    always_comb
    begin
        state_next = state_reg;
        save_sub_next = save_sub_reg;
        mark1_next = mark1_reg;
        mark2_next = mark2_reg;
        disc_next  = disc_reg;
        scat_next  = scat_reg;
        ssub_next  = ssub_reg;
        cnt_next   = cnt_reg;
        rdata_next = rdata_reg;
        ack_next   = acc;
        wait_next  = ~acc;                                  // low only in the acknowledge cycle
        rst_o_next = 1'b0;
        smark1_next = smark1_reg;
        smark2_next = smark2_reg;
        // write side effects per address group
        if (wr)
        begin
            if (grp_hit(avs_address_in, CSDV_OFS_SAVE))
            begin
                save_sub_next[sub] = avs_writedata_in;
                if (sub != CSDV_SUB_ALL)
                begin
                    mark1_next = CSDV_ZERO;
                    mark2_next = CSDV_ZERO;
                end
                if (state_reg == CSDV_IDLE && avs_writedata_in == CSDV_KEY_SAVE
                    && cat_mask(sub) != 16'h0000)
                begin
                    state_next = CSDV_SAVE;
                    ssub_next  = sub;
                    scat_next  = (sub == CSDV_SUB_ALL) ? CSDV_CAT_FACTORY : cat_mask(sub);
                    cnt_next   = 32'h00000000;
                end
            end
            else if (grp_hit(avs_address_in, CSDV_OFS_DISC))
            begin
                mark1_next = CSDV_ZERO;
                mark2_next = CSDV_ZERO;
                if (avs_writedata_in == CSDV_KEY_DISCARD)
                    disc_next = disc_reg | cat_mask(sub);
            end
            else if (avs_address_in == CSDV_OFS_REBOOT)
            begin
                mark1_next = CSDV_ZERO;
                mark2_next = CSDV_ZERO;
                if (avs_writedata_in == CSDV_KEY_REBOOT)
                    rst_o_next = 1'b1;
            end
            else if (avs_address_in == CSDV_OFS_MARK1)
                mark1_next = avs_writedata_in;
            else if (avs_address_in == CSDV_OFS_MARK2)
                mark2_next = avs_writedata_in;
            else if (avs_address_in == CSDV_OFS_OBJ)
            begin
                mark1_next = CSDV_ZERO;
                mark2_next = CSDV_ZERO;
            end
        end
        // read data mux, held until the next read
        if (rd)
        begin
            if (grp_hit(avs_address_in, CSDV_OFS_SAVE))
                rdata_next = save_sub_reg[sub];
            else if (avs_address_in == CSDV_OFS_MARK1)
                rdata_next = mark1_reg;
            else if (avs_address_in == CSDV_OFS_MARK2)
                rdata_next = mark2_reg;
            else if (avs_address_in == CSDV_OFS_STATUS)
                rdata_next = {16'h0000, disc_reg};
            else if (avs_address_in == CSDV_OFS_BUSY)
                rdata_next = {29'h00000000, state_reg};
            else
                rdata_next = CSDV_ZERO;
        end
        // save engine: count, then post the done value
        unique case (state_reg)
            CSDV_IDLE: ;
            CSDV_SAVE:
            begin
                cnt_next = cnt_reg + 32'h00000001;
                if (cnt_reg == SAVE_CYC - 1)
                begin
                    state_next = CSDV_DONE;
                    if (ssub_reg == CSDV_SUB_ALL)
                    begin
                        smark1_next = mark1_reg;
                        smark2_next = mark2_reg;
                    end
                end
            end
            CSDV_DONE:
            begin
                save_sub_next[ssub_reg] = CSDV_SAVE_DONE;
                scat_next  = 16'h0000;
                state_next = CSDV_IDLE;
            end
        endcase
        // restart drops pending discards and reloads saved markers
        if (rst_o_reg)
        begin
            disc_next  = 16'h0000;                          // applied at restart
            mark1_next = smark1_reg;
            mark2_next = smark2_reg;
        end
    end

    // registers
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= CSDV_IDLE;
            for (int i = 0; i < 16; i++)
                save_sub_reg[i] <= CSDV_ZERO;
            mark1_reg <= CSDV_ZERO;
            mark2_reg <= CSDV_ZERO;
            smark1_reg <= CSDV_ZERO;
            smark2_reg <= CSDV_ZERO;
            disc_reg  <= 16'h0000;
            scat_reg  <= 16'h0000;
            ssub_reg  <= 4'h0;
            cnt_reg   <= 32'h00000000;
            rdata_reg <= CSDV_ZERO;
            ack_reg   <= 1'b0;
            rst_o_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            save_sub_reg <= save_sub_next;
            mark1_reg <= mark1_next;
            mark2_reg <= mark2_next;
            smark1_reg <= smark1_next;
            smark2_reg <= smark2_next;
            disc_reg  <= disc_next;
            scat_reg  <= scat_next;
            ssub_reg  <= ssub_next;
            cnt_reg   <= cnt_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
            rst_o_reg <= rst_o_next;
        end
    end

    // waitrequest is low only in the acknowledge cycle
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            avs_waitrequest_out <= 1'b1;
        else
            avs_waitrequest_out <= wait_next;
    end

    assign avs_readdata_out = rdata_reg;
    assign restart_out      = rst_o_reg;
    assign save_cat_out     = scat_reg;
    assign discard_pend_out = disc_reg;

    // key handling, markers and completion
    a_done_value: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == CSDV_DONE |=> save_sub_reg[ssub_reg] == CSDV_SAVE_DONE)
        else $error("save completion value not written");
    a_bad_reboot: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_REBOOT && avs_writedata_in != CSDV_KEY_REBOOT
        |=> !restart_out)
        else $error("restart from wrong key");
    a_reboot_go: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_REBOOT && avs_writedata_in == CSDV_KEY_REBOOT
        |=> restart_out)
        else $error("restart missing");
    a_factory_mask: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !discard_pend_out[6] |-> ##1 !(discard_pend_out[6]
        && !$past(wr && grp_hit(avs_address_in, CSDV_OFS_DISC) && sub == CSDV_SUB_TUNING)))
        else $error("tuning discarded without subindex 06");
    a_mark_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_OBJ && !rst_o_reg |=> mark1_reg == CSDV_ZERO && mark2_reg == CSDV_ZERO)
        else $error("marker not cleared");
    a_mark_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_MARK1 && !rst_o_reg
        |=> mark1_reg == $past(avs_writedata_in))
        else $error("marker not written");
    a_disc_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        discard_pend_out[2] && !restart_out |=> discard_pend_out[2])
        else $error("discard lost before restart");
    a_save_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_SAVE + 8'h01 && avs_writedata_in == CSDV_KEY_SAVE
        && state_reg == CSDV_IDLE |=> state_reg == CSDV_SAVE)
        else $error("save not started");

    // discard marking and refusal
    a_disc_single: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && grp_hit(avs_address_in, CSDV_OFS_DISC) && avs_writedata_in == CSDV_KEY_DISCARD
        && sub != CSDV_SUB_ALL && CSDV_CAT_VALID[sub] |=> discard_pend_out[$past(sub)])
        else $error("discard key did not mark its category");
    a_disc_factory: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_DISC + 8'h01 && avs_writedata_in == CSDV_KEY_DISCARD
        |=> discard_pend_out[5:2] == 4'hF)
        else $error("factory discard missed a category");
    a_disc_spare: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_DISC + 8'h01
        |=> (discard_pend_out & (CSDV_CAT_VALID & ~CSDV_CAT_FACTORY))
            == $past(discard_pend_out & (CSDV_CAT_VALID & ~CSDV_CAT_FACTORY)))
        else $error("factory discard touched a spared category");
    a_wrong_disc: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && grp_hit(avs_address_in, CSDV_OFS_DISC) && avs_writedata_in != CSDV_KEY_DISCARD
        |=> discard_pend_out == $past(discard_pend_out))
        else $error("discard from wrong key");

    // save engine and marker handling
    a_wrong_save: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && grp_hit(avs_address_in, CSDV_OFS_SAVE) && avs_writedata_in != CSDV_KEY_SAVE
        && state_reg == CSDV_IDLE |=> state_reg == CSDV_IDLE)
        else $error("save from wrong key");
    a_save_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && grp_hit(avs_address_in, CSDV_OFS_SAVE) && sub != CSDV_SUB_ALL
        |=> mark1_reg == CSDV_ZERO && mark2_reg == CSDV_ZERO)
        else $error("save subindex write kept markers");
    a_save_keep: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && avs_address_in == CSDV_OFS_SAVE + 8'h01
        |=> mark1_reg == $past(mark1_reg) && mark2_reg == $past(mark2_reg))
        else $error("save-all write cleared markers");
    a_save_record: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == CSDV_SAVE && cnt_reg == SAVE_CYC - 1 && ssub_reg == CSDV_SUB_ALL
        |=> smark1_reg == $past(mark1_reg) && smark2_reg == $past(mark2_reg))
        else $error("markers not stored with save-all");
    a_save_bound: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        state_reg == CSDV_SAVE |-> cnt_reg < SAVE_CYC)
        else $error("save ran past its length");

    // restart and bus handshake
    a_restart_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        restart_out |=> !restart_out)
        else $error("restart longer than one cycle");
    a_restart_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        restart_out |=> discard_pend_out == 16'h0000)
        else $error("pending discards kept past restart");
    a_restart_marks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        restart_out |=> mark1_reg == $past(smark1_reg) && mark2_reg == $past(smark2_reg))
        else $error("markers not reloaded at restart");
    a_wait_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");

    // main scenarios
    c_save_all: cover property (@(posedge sys_clk_in) state_reg == CSDV_DONE && ssub_reg == CSDV_SUB_ALL);
    c_discard: cover property (@(posedge sys_clk_in) discard_pend_out != 16'h0000);
    c_restart: cover property (@(posedge sys_clk_in) restart_out);
    c_tuning_disc: cover property (@(posedge sys_clk_in) discard_pend_out[6]);
    c_save_refused: cover property (@(posedge sys_clk_in) wr && grp_hit(avs_address_in, CSDV_OFS_SAVE)
        && avs_writedata_in == CSDV_KEY_SAVE && state_reg != CSDV_IDLE);
endmodule // csdv_store

// ### tb/csdv_master.sv
// partner model: configuration master on the avalon-mm register port
// assumes the slave stalls with waitrequest and drops it once per access
`timescale 1ns/100ps
module csdv_master (
    input  wire logic        sys_clk_in, // bench clock
    input  wire logic        wait_in,    // slave stall
    input  wire logic [31:0] rdata_in,   // slave read data
    output logic      [7:0]  addr_out,   // word address
    output logic             read_out,   // read strobe
    output logic             write_out,  // write strobe
    output logic      [31:0] wdata_out,  // write data
    output logic             hang_out    // slave never answered
);
    initial {addr_out, read_out, write_out, wdata_out, hang_out} = '0;
    // one access, held until waitrequest is sampled low or 64 cycles pass; reads and writes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk_in);
        addr_out  <= a;
        wdata_out <= d;
        write_out <= w;
        read_out  <= !w;
        n = 0;
        do
        begin
            @(posedge sys_clk_in);
            n++;
        end
        while (wait_in !== 1'b0 && n < 64);
        q = rdata_in;
        hang_out  <= hang_out | (wait_in !== 1'b0);
        // released address and data lines show the inverse, not the old value; strobes go low
        addr_out  <= ~a;
        wdata_out <= ~d;
        write_out <= 1'b0;
        read_out  <= 1'b0;
    endtask
endmodule // csdv_master

// ### tb/tb_csdv_store.sv
// self-checking bench for the configuration store block
// assumes the partner master in csdv_master and a short save count
`timescale 1ns/100ps
module tb_csdv_store;
    import csdv_pkg::*;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  adr;
    logic        rd_s, wr_s, hang, wt, rst_p;
    logic [31:0] wd, rdat, q, k, m1, m2, seed = 32'h0000DF53;
    logic [15:0] cat, pend, exp;
    logic [3:0]  subs [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hB, 4'hC};
    int          num_errors = 0;
    int          tests_run = 0;
    int          restarts = 0;
    csdv_store #(.SAVE_CYC(8)) csdv_store_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wt), .restart_out(rst_p), .save_cat_out(cat), .discard_pend_out(pend));
    csdv_master csdv_master_i (.sys_clk_in(sys_clk_in), .wait_in(wt), .rdata_in(rdat), .addr_out(adr),
        .read_out(rd_s), .write_out(wr_s), .wdata_out(wd), .hang_out(hang));
    // clock and restart pulse counter
    always #10 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in)
    begin
        if (rst_p === 1'b1)
            restarts++;
        if (hang === 1'b1)
        begin
            $display("MISMATCH %0t bus hang", $time);
            num_errors++;
            close_out();
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // category mask expected for a subindex
    function automatic logic [15:0] cat_mask(input logic [3:0] s);
        return (s == CSDV_SUB_ALL) ? 16'h003C : (16'h0001 << s);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        csdv_master_i.xfer(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        csdv_master_i.xfer(1'b0, a, 32'h00000000, d);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
            num_errors++;
        end
    endtask
    // poll a save subindex until the done value shows
    task automatic poll(input logic [7:0] a);
        int n;
        n = 0;
        q = CSDV_ZERO;
        while (q !== CSDV_SAVE_DONE && n < 50)
        begin
            rd(a, q);
            n++;
        end
        if (q !== CSDV_SAVE_DONE)
        begin
            $display("MISMATCH %0t save never finished", $time);
            num_errors++;
            close_out();
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        m1 = rnd() | 32'h00000001;
        m2 = rnd() | 32'h00000001;
        k = rnd() | 32'h80000000;
        wr(CSDV_OFS_MARK1, m1);
        wr(CSDV_OFS_MARK2, m2);
        rd(CSDV_OFS_MARK1, q);
        chk(q, m1);
        wr(CSDV_OFS_OBJ, rnd());
        rd(CSDV_OFS_MARK2, q);
        chk(q, CSDV_ZERO);
        wr(CSDV_OFS_MARK1, m1);
        wr(CSDV_OFS_MARK2, m2);
        wr(CSDV_OFS_SAVE + 8'h01, k);
        @(negedge sys_clk_in);
        chk({16'h0000, cat}, CSDV_ZERO);
        rd(CSDV_OFS_SAVE + 8'h01, q);
        chk(q, k);
        rd(CSDV_OFS_MARK1, q);
        chk(q, m1);
        wr(CSDV_OFS_SAVE + 8'h01, CSDV_KEY_SAVE);
        @(negedge sys_clk_in);
        chk({16'h0000, cat}, 32'h0000003C);
        poll(CSDV_OFS_SAVE + 8'h01);
        chk(q, CSDV_SAVE_DONE);
        chk({16'h0000, cat}, CSDV_ZERO);
        // each valid discard subindex, a wrong key first
        exp = 16'h0000;
        foreach (subs[i])
        begin
            wr(CSDV_OFS_DISC + {4'h0, subs[i]}, k);
            rd(CSDV_OFS_STATUS, q);
            chk(q, {16'h0000, exp});
            wr(CSDV_OFS_DISC + {4'h0, subs[i]}, CSDV_KEY_DISCARD);
            exp = exp | cat_mask(subs[i]);
            rd(CSDV_OFS_STATUS, q);
            chk(q, {16'h0000, exp});
        end
        chk({16'h0000, pend}, {16'h0000, exp});
        rd(CSDV_OFS_MARK1, q);
        chk(q, CSDV_ZERO);
        wr(CSDV_OFS_REBOOT, k);
        repeat (3) @(negedge sys_clk_in);
        chk(restarts, 0);
        wr(CSDV_OFS_REBOOT, CSDV_KEY_REBOOT);
        repeat (3) @(negedge sys_clk_in);
        chk(restarts, 1);
        rd(CSDV_OFS_STATUS, q);
        chk(q, CSDV_ZERO);
        rd(CSDV_OFS_MARK1, q);
        chk(q, m1);
        rd(CSDV_OFS_MARK2, q);
        chk(q, m2);
        wr(CSDV_OFS_SAVE + 8'h02, CSDV_KEY_SAVE);
        @(negedge sys_clk_in);
        chk({16'h0000, cat}, 32'h00000004);
        poll(CSDV_OFS_SAVE + 8'h02);
        chk(q, CSDV_SAVE_DONE);
        rd(CSDV_OFS_MARK1, q);
        chk(q, CSDV_ZERO);
        // save key to an unused subindex, then a second save while one runs
        wr(CSDV_OFS_SAVE + 8'h07, CSDV_KEY_SAVE);
        rd(CSDV_OFS_BUSY, q);
        chk(q, 32'h00000001);
        wr(CSDV_OFS_SAVE + 8'h06, CSDV_KEY_SAVE);
        rd(CSDV_OFS_BUSY, q);
        chk(q, 32'h00000002);
        wr(CSDV_OFS_SAVE + 8'h03, CSDV_KEY_SAVE);
        poll(CSDV_OFS_SAVE + 8'h06);
        chk(q, CSDV_SAVE_DONE);
        rd(CSDV_OFS_SAVE + 8'h03, q);
        chk(q, CSDV_KEY_SAVE);
        rd(CSDV_OFS_SAVE + 8'h07, q);
        chk(q, CSDV_KEY_SAVE);
        rd(8'h30, q);
        chk(q, CSDV_ZERO);
        close_out();
    end
endmodule // tb_csdv_store
